/* hw/imab_defines.vh */
// Register offsets, field positions and reset values of the I2C master arbitration block
`ifndef IMAB_DEFINES_VH
`define IMAB_DEFINES_VH

// ----------------------------------------
// Register indices (byte addresses)
// ----------------------------------------
`define IMAB_OFS_RELOAD   4'h0
`define IMAB_OFS_BUF      4'h1
`define IMAB_OFS_CTL1     4'h2
`define IMAB_OFS_CTL2     4'h3
`define IMAB_OFS_CTL3     4'h4
`define IMAB_OFS_MASK     4'h5
`define IMAB_OFS_STATUS   4'h6
`define IMAB_OFS_EVENTS   4'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IMAB_ST_SMP       7
`define IMAB_ST_CKE       6
`define IMAB_ST_DATA      5
`define IMAB_ST_STOP      4
`define IMAB_ST_START     3
`define IMAB_ST_RW        2
`define IMAB_ST_UA        1
`define IMAB_ST_BF        0
`define IMAB_C1_ENABLE    5
`define IMAB_C2_ACK       4
`define IMAB_C2_RCV       3
`define IMAB_C2_STOP      2
`define IMAB_C2_RESTART   1
`define IMAB_C2_START     0
`define IMAB_EV_COLL      0
`define IMAB_EV_DONE      1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IMAB_RST_BYTE     8'h00

`endif

/* hw/imab_baud_counter.v */
// Reloadable down counter that paces the serial clock
`timescale 1ns/1ps
`default_nettype none

module imab_baud_counter #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Control
    input  wire             load,
    input  wire             run,
    input  wire [WIDTH-1:0] reload,
    // Status
    output reg              expired
);

    reg [WIDTH-1:0] count_r;
    reg             tick_r;

    // Steps on alternate clocks: one rollover spans 2*(reload+1) clocks
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= {WIDTH{1'b0}};
            tick_r  <= 1'b0;
            expired <= 1'b0;
        end else if (load) begin
            count_r <= reload;
            tick_r  <= 1'b0;
            expired <= 1'b0;
        end else if (run) begin
            tick_r <= ~tick_r;
            if (tick_r && count_r != {WIDTH{1'b0}})
                count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
            expired <= (count_r == {WIDTH{1'b0}}) && (!tick_r || expired);
        end else begin
            expired <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* hw/imab_top.v */
// I2C master conditions with collision checks, baud counter and status register
`timescale 1ns/1ps
`default_nettype none
`include "imab_defines.vh"

// How it works
// - Restart: data low at clock rise collides
// - Restart: clock falls before data low collides
// - Restart: release data, count, release clock
// - Restart: high sample reloads, early fall ok
// - Restart: clock fall before expiry collides
// - Restart: drive data, count, drive clock
// - Stop: data low after expiry collides
// - Stop: clock low before data high collides
// - Stop: data low, release clock, count, sample
// - One counter; buffer write starts it
// - Counter stops, clock holds when done
// - Counter reloads twice per serial period
// - Serial clock is osc/((reload+1)*4)
// - Status bit 7 sample phase/slew select
// - Status bit 6 edge/threshold select
// - Status bit 5 data versus address
// - Status bit 4 stop seen last
// - Status bit 3 start seen last
// - Status bit 2 direction or transmitting
// - Idle when no request and no transmit
// - Status bit 1 address update needed
// - Collision sets flag, port goes idle
// - Collision aborts condition, releases lines, clears request
module imab_top #(
    parameter RELOAD_WIDTH = 8
) (
    // Clock and reset
    input  wire       CORE_CLK,
    input  wire       NRST,
    // Register port
    input  wire [3:0] ADDR,
    input  wire [7:0] WDATA,
    input  wire       WR,
    input  wire       RD,
    output reg  [7:0] RDATA,
    // Data line
    input  wire       DATA_LINE_IN,
    output reg        DATA_LINE_OUT,
    output reg        DATA_LINE_OE_N,
    // Clock line
    input  wire       CLOCK_LINE_IN,
    output reg        CLOCK_LINE_OUT,
    output reg        CLOCK_LINE_OE_N,
    // Events
    output reg        BUS_COLLISION,
    output reg        PORT_IDLE
);

    // ----------------------------------------
    // States, one-hot
    // ----------------------------------------
    localparam [8:0] ST_IDLE     = 9'h001;
    localparam [8:0] ST_RS_REL   = 9'h002;
    localparam [8:0] ST_RS_CKHI  = 9'h004;
    localparam [8:0] ST_RS_HOLD  = 9'h008;
    localparam [8:0] ST_RS_DLOW  = 9'h010;
    localparam [8:0] ST_SP_DLOW  = 9'h020;
    localparam [8:0] ST_SP_CKHI  = 9'h040;
    localparam [8:0] ST_SP_WAIT  = 9'h080;
    localparam [8:0] ST_XFER     = 9'h100;

    // ----------------------------------------
    // Line synchronisers
    // ----------------------------------------
    reg [2:0] sda_sync_r;
    reg [2:0] scl_sync_r;
    reg       sda_r;
    reg       scl_r;

    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            sda_sync_r <= 3'h7;
            scl_sync_r <= 3'h7;
            sda_r      <= 1'b1;
            scl_r      <= 1'b1;
        end else begin
            sda_sync_r <= {sda_sync_r[1:0], DATA_LINE_IN};
            scl_sync_r <= {scl_sync_r[1:0], CLOCK_LINE_IN};
            if (sda_sync_r[2] == sda_sync_r[1])
                sda_r <= sda_sync_r[1];
            if (scl_sync_r[2] == scl_sync_r[1])
                scl_r <= scl_sync_r[1];
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] reload_r;
    reg [7:0] buf_r;
    reg [7:0] ctl1_r;
    reg [7:0] ctl2_r;
    reg [7:0] ctl3_r;
    reg [7:0] mask_r;
    reg [1:0] stat_cfg_r;
    reg       data_addr_r;
    reg       stop_seen_r;
    reg       start_seen_r;
    reg       dir_r;
    reg       addr_upd_r;
    reg       buf_full_r;
    reg       coll_flag_r;
    reg       done_flag_r;
    reg [8:0] state_r;
    reg [8:0] state_nxt;
    reg       sda_prev_r;
    reg       scl_prev_r;
    reg [3:0] xfer_half_r;

    wire port_on = ctl1_r[`IMAB_C1_ENABLE];
    wire is_idle = ~dir_r & ~|ctl2_r[`IMAB_C2_ACK:`IMAB_C2_START];
    wire wr_buf  = WR && ADDR == `IMAB_OFS_BUF;

    // ----------------------------------------
    // Baud counter
    // ----------------------------------------
    reg  cnt_load;
    reg  cnt_run;
    wire cnt_exp;

    imab_baud_counter #(
        .WIDTH (RELOAD_WIDTH)
    ) u_baud (
        .clk     (CORE_CLK),
        .rst_n   (NRST),
        .load    (cnt_load),
        .run     (cnt_run),
        .reload  (reload_r),
        .expired (cnt_exp)
    );

    // ----------------------------------------
    // Condition sequencer
    // ----------------------------------------
    reg coll;
    reg done;
    reg sda_drive_low;
    reg scl_drive_low;
    reg sda_hold_r;
    reg scl_hold_r;

    always @* begin
        state_nxt     = state_r;
        cnt_load      = 1'b0;
        cnt_run       = 1'b0;
        coll          = 1'b0;
        done          = 1'b0;
        sda_drive_low = sda_hold_r;
        scl_drive_low = scl_hold_r;
        case (state_r)
            ST_IDLE: begin
                cnt_run = 1'b0;
                if (port_on && ctl2_r[`IMAB_C2_RESTART]) begin
                    state_nxt     = ST_RS_REL;
                    cnt_load      = 1'b1;
                    sda_drive_low = 1'b0;
                end else if (port_on && ctl2_r[`IMAB_C2_STOP]) begin
                    state_nxt     = ST_SP_DLOW;
                    sda_drive_low = 1'b1;
                end else if (port_on && wr_buf && is_idle) begin
                    state_nxt = ST_XFER;
                    cnt_load  = 1'b1;
                end
            end
            ST_RS_REL: begin
                cnt_run = 1'b1;
                if (cnt_exp) begin
                    scl_drive_low = 1'b0;
                    state_nxt     = ST_RS_CKHI;
                end
            end
            ST_RS_CKHI: begin
                if (scl_r && !scl_prev_r || scl_r) begin
                    if (!sda_r) begin
                        coll = 1'b1;
                    end else begin
                        cnt_load  = 1'b1;
                        state_nxt = ST_RS_HOLD;
                    end
                end
            end
            ST_RS_HOLD: begin
                cnt_run = 1'b1;
                if (!scl_r) begin
                    coll = 1'b1;
                end else if (cnt_exp && sda_r) begin
                    sda_drive_low = 1'b1;
                    cnt_load      = 1'b1;
                    state_nxt     = ST_RS_DLOW;
                end else if (cnt_exp) begin
                    // Another master pulled data first: no collision
                    cnt_load  = 1'b1;
                    state_nxt = ST_RS_DLOW;
                end
            end
            ST_RS_DLOW: begin
                cnt_run = 1'b1;
                if (cnt_exp) begin
                    scl_drive_low = 1'b1;
                    done          = 1'b1;
                end
            end
            ST_SP_DLOW: begin
                if (!sda_r) begin
                    scl_drive_low = 1'b0;
                    state_nxt     = ST_SP_CKHI;
                end
            end
            ST_SP_CKHI: begin
                if (scl_r) begin
                    cnt_load  = 1'b1;
                    state_nxt = ST_SP_WAIT;
                end
            end
            ST_SP_WAIT: begin
                cnt_run = 1'b1;
                if (!scl_r) begin
                    coll = 1'b1;
                end else if (cnt_exp && sda_hold_r) begin
                    sda_drive_low = 1'b0;
                    cnt_load      = 1'b1;
                end else if (cnt_exp) begin
                    if (!sda_r)
                        coll = 1'b1;
                    else
                        done = 1'b1;
                end
            end
            ST_XFER: begin
                // Serial clock for 16 halves: each expiry toggles the clock half
                cnt_run = 1'b1;
                if (cnt_exp) begin
                    cnt_load      = 1'b1;
                    scl_drive_low = ~scl_hold_r;
                    if (xfer_half_r == 4'hf)
                        done = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (coll || done || !port_on) begin
            state_nxt = ST_IDLE;
            cnt_load  = 1'b0;
        end
        if (coll || !port_on) begin
            sda_drive_low = 1'b0;
            scl_drive_low = 1'b0;
        end
    end

    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            state_r     <= ST_IDLE;
            sda_hold_r  <= 1'b0;
            scl_hold_r  <= 1'b0;
            sda_prev_r  <= 1'b1;
            scl_prev_r  <= 1'b1;
            xfer_half_r <= 4'h0;
        end else begin
            state_r    <= state_nxt;
            sda_hold_r <= sda_drive_low;
            scl_hold_r <= scl_drive_low;
            sda_prev_r <= sda_r;
            scl_prev_r <= scl_r;
            if (state_r != ST_XFER)
                xfer_half_r <= 4'h0;
            else if (cnt_exp)
                xfer_half_r <= xfer_half_r + 4'h1;
        end
    end

    // ----------------------------------------
    // Register writes and status updates
    // ----------------------------------------
    wire start_edge = scl_r && sda_prev_r && !sda_r;
    wire stop_edge  = scl_r && !sda_prev_r && sda_r;

    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            reload_r     <= `IMAB_RST_BYTE;
            buf_r        <= `IMAB_RST_BYTE;
            ctl1_r       <= `IMAB_RST_BYTE;
            ctl2_r       <= `IMAB_RST_BYTE;
            ctl3_r       <= `IMAB_RST_BYTE;
            mask_r       <= `IMAB_RST_BYTE;
            stat_cfg_r   <= 2'h0;
            data_addr_r  <= 1'b0;
            stop_seen_r  <= 1'b0;
            start_seen_r <= 1'b0;
            dir_r        <= 1'b0;
            addr_upd_r   <= 1'b0;
            buf_full_r   <= 1'b0;
            coll_flag_r  <= 1'b0;
            done_flag_r  <= 1'b0;
        end else begin
            if (WR) begin
                if (ADDR == `IMAB_OFS_RELOAD) begin
                    reload_r   <= WDATA;
                    addr_upd_r <= 1'b0;
                end else if (ADDR == `IMAB_OFS_BUF) begin
                    if (is_idle) begin
                        buf_r       <= WDATA;
                        data_addr_r <= 1'b1;
                    end
                end else if (ADDR == `IMAB_OFS_CTL1) begin
                    ctl1_r <= WDATA;
                end else if (ADDR == `IMAB_OFS_CTL2) begin
                    // Requests may only be raised while idle
                    if (is_idle)
                        ctl2_r <= WDATA;
                end else if (ADDR == `IMAB_OFS_CTL3) begin
                    ctl3_r <= WDATA;
                end else if (ADDR == `IMAB_OFS_MASK) begin
                    mask_r <= WDATA;
                end else if (ADDR == `IMAB_OFS_STATUS) begin
                    stat_cfg_r <= WDATA[`IMAB_ST_SMP:`IMAB_ST_CKE];
                end else if (ADDR == `IMAB_OFS_EVENTS) begin
                    if (WDATA[`IMAB_EV_COLL])
                        coll_flag_r <= 1'b0;
                    if (WDATA[`IMAB_EV_DONE])
                        done_flag_r <= 1'b0;
                end
            end
            if (wr_buf && is_idle && port_on) begin
                dir_r      <= 1'b1;
                buf_full_r <= 1'b1;
            end
            if (done || coll) begin
                ctl2_r[`IMAB_C2_ACK:`IMAB_C2_START] <= 5'h00;
                dir_r      <= 1'b0;
                buf_full_r <= 1'b0;
            end
            if (done)
                done_flag_r <= 1'b1;
            if (coll)
                coll_flag_r <= 1'b1;
            if (ctl1_r[3:0] == 4'h7 && start_edge)
                addr_upd_r <= 1'b1;
            if (!port_on) begin
                stop_seen_r  <= 1'b0;
                start_seen_r <= 1'b0;
            end else if (start_edge) begin
                start_seen_r <= 1'b1;
                stop_seen_r  <= 1'b0;
                data_addr_r  <= 1'b0;
            end else if (stop_edge) begin
                stop_seen_r  <= 1'b1;
                start_seen_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Read data and pins
    // ----------------------------------------
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            RDATA           <= 8'h00;
            DATA_LINE_OUT   <= 1'b0;
            DATA_LINE_OE_N  <= 1'b1;
            CLOCK_LINE_OUT  <= 1'b0;
            CLOCK_LINE_OE_N <= 1'b1;
            BUS_COLLISION   <= 1'b0;
            PORT_IDLE       <= 1'b1;
        end else begin
            RDATA <= 8'h00;
            if (RD) begin
                if (ADDR == `IMAB_OFS_RELOAD)
                    RDATA <= reload_r;
                else if (ADDR == `IMAB_OFS_BUF)
                    RDATA <= buf_r;
                else if (ADDR == `IMAB_OFS_CTL1)
                    RDATA <= ctl1_r;
                else if (ADDR == `IMAB_OFS_CTL2)
                    RDATA <= ctl2_r;
                else if (ADDR == `IMAB_OFS_CTL3)
                    RDATA <= ctl3_r;
                else if (ADDR == `IMAB_OFS_MASK)
                    RDATA <= mask_r;
                else if (ADDR == `IMAB_OFS_STATUS)
                    RDATA <= {stat_cfg_r, data_addr_r, stop_seen_r, start_seen_r,
                              dir_r, addr_upd_r, buf_full_r};
                else if (ADDR == `IMAB_OFS_EVENTS)
                    RDATA <= {6'h00, done_flag_r, coll_flag_r};
            end
            DATA_LINE_OE_N  <= ~sda_drive_low;
            CLOCK_LINE_OE_N <= ~scl_drive_low;
            BUS_COLLISION   <= coll_flag_r;
            PORT_IDLE       <= is_idle;
        end
    end

endmodule

`default_nettype wire

/* bench/imab_bus_model.sv */
// Far-side bus party: pull-ups and a second master that can pull lines low
`timescale 1ns/1ps
`default_nettype none

module imab_bus_model (
    // Device pins
    input  wire logic sda_out,
    input  wire logic sda_oe_n,
    input  wire logic scl_out,
    input  wire logic scl_oe_n,
    // Commands from the bench
    input  wire logic hold_sda,
    input  wire logic hold_scl,
    // Wired levels
    output wire logic sda,
    output wire logic scl
);
    // Pull-up unless someone pulls low
    assign sda = (sda_oe_n | sda_out) & ~hold_sda;
    assign scl = (scl_oe_n | scl_out) & ~hold_scl;
endmodule

`default_nettype wire

/* bench/imab_top_assertions.sv */
// Port checker for the I2C master arbitration block
`timescale 1ns/1ps
`default_nettype none

module imab_checker (
    // Clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       NRST,
    // Register port
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    input  wire logic [7:0] RDATA,
    // Bus lines
    input  wire logic       DATA_LINE_OUT,
    input  wire logic       DATA_LINE_OE_N,
    input  wire logic       CLOCK_LINE_OUT,
    input  wire logic       CLOCK_LINE_OE_N,
    // Events
    input  wire logic       BUS_COLLISION,
    input  wire logic       PORT_IDLE
);
    wire clr_coll = WR && ADDR == 4'h7 && WDATA[0];

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside its slot");
    a_unmapped_zero: assert property (RD && ADDR[3] |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_open_drain: assert property (DATA_LINE_OUT == 1'b0 && CLOCK_LINE_OUT == 1'b0)
        else $error("line driven high");
    a_coll_release: assert property ($rose(BUS_COLLISION) |->
        DATA_LINE_OE_N && CLOCK_LINE_OE_N) else $error("lines held after collision");
    a_coll_idle: assert property ($rose(BUS_COLLISION) |-> ##[0:2] PORT_IDLE)
        else $error("port not idle after collision");
    a_stop_busy: assert property (PORT_IDLE && WR && ADDR == 4'h3 && WDATA[2]
        |=> ##[0:1] !PORT_IDLE) else $error("idle with request pending");
    a_coll_sticky: assert property ($fell(BUS_COLLISION) |->
        $past(clr_coll) || $past(clr_coll, 2)) else $error("collision flag lost");
    a_idle_quiet: assert property (PORT_IDLE [*3] |->
        $stable(CLOCK_LINE_OE_N) && $stable(DATA_LINE_OE_N))
        else $error("lines move while idle");

    c_collision: cover property ($rose(BUS_COLLISION));
    c_clock_held: cover property ($fell(CLOCK_LINE_OE_N) && !DATA_LINE_OE_N);
    c_stop_edge: cover property ($rose(DATA_LINE_OE_N) && CLOCK_LINE_OE_N);
endmodule

bind imab_top imab_checker chk_u (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .DATA_LINE_OUT(DATA_LINE_OUT), .DATA_LINE_OE_N(DATA_LINE_OE_N),
    .CLOCK_LINE_OUT(CLOCK_LINE_OUT), .CLOCK_LINE_OE_N(CLOCK_LINE_OE_N),
    .BUS_COLLISION(BUS_COLLISION), .PORT_IDLE(PORT_IDLE)
);

`default_nettype wire

/* bench/tb_imab_top.sv */
// Self-checking bench for the I2C master arbitration block
`timescale 1ns/1ps
`default_nettype none

module tb_imab_top;
    logic       core_clk = 1'b0;
    logic       nrst     = 1'b0;
    logic [3:0] addr     = 4'h0;
    logic [7:0] wdata    = 8'h00;
    logic       wr       = 1'b0;
    logic       rd       = 1'b0;
    logic       hold_sda = 1'b0;
    logic       hold_scl = 1'b0;
    wire  [7:0] rdata;
    wire        sda, scl, sda_out, scl_out, sda_oe_n, scl_oe_n, bus_coll, port_idle;
    int         num_errors = 0;
    int         compares   = 0;
    int         t_sf, t_sr, t_cf, t_cr, t_c1, t_c2, ntog;

    always #50 core_clk = ~core_clk;

    imab_top dut_u (
        .CORE_CLK(core_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .DATA_LINE_IN(sda), .DATA_LINE_OUT(sda_out),
        .DATA_LINE_OE_N(sda_oe_n), .CLOCK_LINE_IN(scl), .CLOCK_LINE_OUT(scl_out),
        .CLOCK_LINE_OE_N(scl_oe_n), .BUS_COLLISION(bus_coll), .PORT_IDLE(port_idle)
    );

    imab_bus_model bus_u (
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .hold_sda(hold_sda), .hold_scl(hold_scl), .sda(sda), .scl(scl)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic end_sim;
        $display("Compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        @(negedge core_clk);
        check(rdata & m, e);
    endtask

    // Follow one condition; other master pulls a line at a given cycle
    task automatic watch(input int s_at, input int c_at);
        int   cyc;
        logic ps, pc;
        cyc = 0;
        ps = sda_oe_n;
        pc = scl_oe_n;
        t_sf = -1; t_sr = -1; t_cf = -1; t_cr = -1; t_c1 = -1; t_c2 = -1; ntog = 0;
        while ((!port_idle || cyc < 4) && cyc < 400) begin
            @(posedge core_clk);
            cyc++;
            if (cyc == s_at) hold_sda <= 1'b1;
            if (cyc == c_at) hold_scl <= 1'b1;
            @(negedge core_clk);
            if (cyc == 3) check(8'(port_idle), 8'h00);
            if (scl_oe_n !== pc) begin
                ntog++;
                if (ntog == 1) t_c1 = cyc;
                if (ntog == 2) t_c2 = cyc;
                if (scl_oe_n) t_cr = cyc; else t_cf = cyc;
            end
            if (sda_oe_n !== ps) begin
                if (sda_oe_n) t_sr = cyc; else t_sf = cyc;
            end
            ps = sda_oe_n;
            pc = scl_oe_n;
        end
        if (cyc >= 400) begin
            num_errors++;
            $display("BAD %0t condition never finished", $time);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        check(8'({sda_oe_n, scl_oe_n, port_idle, bus_coll}), 8'h0e);
        rd_chk(4'h6, 8'hff, 8'h00);
        rd_chk(4'h7, 8'hff, 8'h00);
        wr_reg(4'h6, 8'hff);
        rd_chk(4'h6, 8'hff, 8'hc0);
        rd_chk(4'h9, 8'hff, 8'h00);
        wr_reg(4'h6, 8'h00);
        $display("Test reset and registers done");
    endtask

    task automatic cond(input logic [7:0] req, input int s_at, input int c_at,
                        input logic coll);
        wr_reg(4'h3, req);
        watch(s_at, c_at);
        @(negedge core_clk);
        check(8'(bus_coll), 8'(coll));
        if (coll) check(8'({sda_oe_n, scl_oe_n}), 8'h03);
        rd_chk(4'h7, 8'h03, coll ? 8'h01 : 8'h02);
        rd_chk(4'h3, 8'h06, 8'h00);
        @(posedge core_clk);
        hold_sda <= 1'b0;
        hold_scl <= 1'b0;
        wr_reg(4'h7, 8'h03);
        repeat (2) @(negedge core_clk);
        check(8'(bus_coll), 8'h00);
        $display("Test condition %h done", req);
    endtask

    task automatic t_restart_ok;
        cond(8'h02, 0, 0, 1'b0);
        check(8'(t_cf - t_sf), 8'd8);
        check(8'({sda_oe_n, scl_oe_n}), 8'h00);
        rd_chk(4'h6, 8'h18, 8'h08);
    endtask

    task automatic t_stop_ok;
        cond(8'h04, 0, 0, 1'b0);
        check(8'(t_sr - t_cr >= 4), 8'h01);
        check(8'({sda_oe_n, scl_oe_n}), 8'h03);
        rd_chk(4'h6, 8'h18, 8'h10);
    endtask

    task automatic t_disable;
        wr_reg(4'h2, 8'h08);
        rd_chk(4'h6, 8'h18, 8'h00);
        wr_reg(4'h2, 8'h27);
        @(posedge core_clk);
        hold_sda <= 1'b1;
        repeat (6) @(posedge core_clk);
        hold_sda <= 1'b0;
        repeat (6) @(posedge core_clk);
        rd_chk(4'h6, 8'h02, 8'h02);
        wr_reg(4'h0, 8'h03);
        rd_chk(4'h6, 8'h02, 8'h00);
        wr_reg(4'h2, 8'h28);
        $display("Test port disable done");
    endtask

    task automatic t_baud;
        wr_reg(4'h0, 8'h03);
        wr_reg(4'h1, 8'h55);
        watch(0, 0);
        check(8'(t_c2 - t_c1), 8'd8);
        check(8'(ntog), 8'd16);
        rd_chk(4'h6, 8'h25, 8'h20);
        $display("Test baud clock done");
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset;
        wr_reg(4'h0, 8'h03);
        wr_reg(4'h2, 8'h28);
        t_restart_ok;
        t_stop_ok;
        t_disable;
        cond(8'h02, 1, 0, 1'b1);
        wr_reg(4'h0, 8'h10);
        cond(8'h02, 0, 50, 1'b1);
        cond(8'h02, 50, 0, 1'b0);
        cond(8'h04, 1, 0, 1'b1);
        cond(8'h04, 0, 12, 1'b1);
        t_baud;
        end_sim;
    end

    initial begin
        #2000000;
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        end_sim;
    end
endmodule

`default_nettype wire
